// File: edo_dram_pkg.sv
// Constants and carrier types for the EDO / fast page DRAM controller
package edo_dram_pkg;

   // ----------------------------------------------------------------
   // Clock and cycle timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PS_PER_NS = 1000;
   // Boot profile (18.432 MHz bus), works with fast page and EDO
   localparam int RCD_SLOW_NS = 40;
   localparam int CAS_SLOW_NS = 30;
   localparam int CP_SLOW_NS = 25;
   localparam int RP_SLOW_NS = 60;
   localparam int RASREF_SLOW_NS = 70;
   // Shortened EDO-only profile (36.864 MHz bus)
   localparam int RCD_FAST_NS = 20;
   localparam int CAS_FAST_NS = 15;
   localparam int CP_FAST_NS = 10;
   localparam int RP_FAST_NS = 40;
   localparam int RASREF_FAST_NS = 50;

   localparam logic [3:0] RCD_SLOW_CYC = 4'((RCD_SLOW_NS * PS_PER_NS
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] CAS_SLOW_CYC = 4'((CAS_SLOW_NS * PS_PER_NS
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] CP_SLOW_CYC = 4'((CP_SLOW_NS * PS_PER_NS
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] RP_SLOW_CYC = 4'((RP_SLOW_NS * PS_PER_NS
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] RASREF_SLOW_CYC = 4'((RASREF_SLOW_NS
      * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] RCD_FAST_CYC = 4'((RCD_FAST_NS * PS_PER_NS
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] CAS_FAST_CYC = 4'((CAS_FAST_NS * PS_PER_NS
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] CP_FAST_CYC = 4'((CP_FAST_NS * PS_PER_NS
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] RP_FAST_CYC = 4'((RP_FAST_NS * PS_PER_NS
      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] RASREF_FAST_CYC = 4'((RASREF_FAST_NS
      * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // ----------------------------------------------------------------
   // Configuration, decode and address mapping
   // ----------------------------------------------------------------
   localparam int WIDTH_SEL_BIT = 2;
   localparam logic WIDTH_X16 = 1'b1;
   localparam int PREFIX_HI = 31;
   localparam int PREFIX_LO = 28;
   localparam int BANK_BIT = 28;
   localparam logic [3:0] BANK0_PREFIX = 4'hC;
   localparam logic [3:0] BANK1_PREFIX = 4'hD;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [3:0] LANES_ALL = 4'hF;
   localparam logic [3:0] LANES_LO = 4'h3;
   localparam logic [3:0] LANES_HI = 4'hC;
   localparam logic [3:0] LANE_ONE = 4'h1;
   localparam logic [3:0] LANE_TWO = 4'h2;
   localparam logic [31:0] STEP_ONE = 32'h1;
   localparam logic [31:0] STEP_TWO = 32'h2;
   // Smallest page: 8 column bits
   localparam logic [31:0] PAGE_MASK_X16 = 32'h000001FF;
   localparam logic [31:0] PAGE_MASK_X32 = 32'h000003FF;
   localparam int DRA_W = 13;
   localparam int DRA_LOW_N = 8;
   localparam int COL16_BASE = 1;
   localparam int COL32_BASE = 2;
   localparam int ROW16_BASE = 9;
   localparam int ROW32_BASE = 10;
   localparam int COL16_HI_BASE = 18;
   localparam int COL32_HI_BASE = 19;
   localparam int ROW16_HI_BASE = 17;
   localparam int ROW32_HI_BASE = 18;
   localparam int HI_STRIDE = 2;
   localparam int SYS_PIN_TOP = 27;
   localparam int SYS_PIN_LOW = 15;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic [1:0] size;
      logic [3:0] beats;
   } bus_req_t;

   typedef struct packed {
      logic [1:0] ras_n;
      logic [3:0] cas_n;
      logic we_n;
   } dram_ctrl_t;

   localparam dram_ctrl_t CTRL_IDLE = '{ras_n: 2'h3, cas_n: 4'hF,
      we_n: 1'b1};

endpackage

// File: edo_dram_controller.sv
// Two-bank EDO / fast page DRAM controller with CBR refresh
`timescale 1ns/1ps

module edo_dram_controller (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [31:0] sys_config_reg_two,
   input wire logic bus_fast,
   input wire logic dram_is_edo,
   input wire logic [15:0] refresh_period_reg,
   input wire logic req_valid,
   input wire edo_dram_pkg::bus_req_t req,
   input wire logic [31:0] wdata,
   output logic req_ready,
   output logic req_error,
   output logic beat_done,
   output logic [31:0] rdata,
   output edo_dram_pkg::dram_ctrl_t column_ctrl,
   output logic [27:15] sys_addr_hi,
   input wire logic [31:0] dq_in,
   output logic [31:0] dq_out,
   output logic dq_oe
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_ROW, S_CAS_LO, S_CAS_HI, S_PRECH, S_REF_CAS, S_REF_RAS
   } fsm_state_t;

   fsm_state_t state_reg, state_next;
   logic [3:0] timer_reg, timer_next;
   logic [31:0] addr_reg, addr_next, step;
   logic [4:0] units_reg, units_next;
   logic x16_reg, x16_next, fast_reg, fast_next, late_reg, late_next;
   logic write_reg, write_next;
   logic [1:0] size_reg, size_next;
   edo_dram_pkg::dram_ctrl_t ctrl_next;
   logic use_col_reg, use_col_next, oe_next, hi_first_reg;
   logic accept, open_row, start_col, load_wr, cap_now, err_next;
   logic ref_start, ref_pend_reg, ref_pend_next, ready_next;
   logic [15:0] ref_cnt_reg;
   logic [31:0] dq_s1_reg, dq_s2_reg;
   logic [1:0] cap_pipe_reg, half_pipe_reg, end_pipe_reg;
   logic [27:15] pin_row, pin_col;

   function automatic logic [3:0] lanes_for(input logic [1:0] size,
      input logic [1:0] a, input logic x16);
      if (x16) begin
         if (size == edo_dram_pkg::SIZE_BYTE) begin
            lanes_for = a[0] ? edo_dram_pkg::LANE_TWO
               : edo_dram_pkg::LANE_ONE;
         end else begin
            lanes_for = edo_dram_pkg::LANES_LO;
         end
      end else if (size == edo_dram_pkg::SIZE_BYTE) begin
         lanes_for = 4'(edo_dram_pkg::LANE_ONE << a);
      end else if (size == edo_dram_pkg::SIZE_HALF) begin
         lanes_for = a[1] ? edo_dram_pkg::LANES_HI
            : edo_dram_pkg::LANES_LO;
      end else begin
         lanes_for = edo_dram_pkg::LANES_ALL;
      end
   endfunction

   // A word on a 16-bit bus ends with its upper half
   function automatic logic ends_beat(input logic [1:0] size,
      input logic a1, input logic x16);
      ends_beat = !(x16 && size == edo_dram_pkg::SIZE_WORD && !a1);
   endfunction

   function automatic logic [3:0] t_rcd(input logic f);
      t_rcd = f ? edo_dram_pkg::RCD_FAST_CYC : edo_dram_pkg::RCD_SLOW_CYC;
   endfunction
   function automatic logic [3:0] t_cas(input logic f);
      t_cas = f ? edo_dram_pkg::CAS_FAST_CYC : edo_dram_pkg::CAS_SLOW_CYC;
   endfunction
   function automatic logic [3:0] t_cp(input logic f);
      t_cp = f ? edo_dram_pkg::CP_FAST_CYC : edo_dram_pkg::CP_SLOW_CYC;
   endfunction
   function automatic logic [3:0] t_rp(input logic f);
      t_rp = f ? edo_dram_pkg::RP_FAST_CYC : edo_dram_pkg::RP_SLOW_CYC;
   endfunction
   function automatic logic [3:0] t_rref(input logic f);
      t_rref = f ? edo_dram_pkg::RASREF_FAST_CYC
         : edo_dram_pkg::RASREF_SLOW_CYC;
   endfunction

   // ----------------------------------------------------------------
   // Row / column multiplexer onto the shared system address pins
   // ----------------------------------------------------------------
   // Bits above the part's capacity are simply not decoded, so small
   // parts alias through the bank space
   for (genvar k = 0; k < edo_dram_pkg::DRA_W; k++) begin : g_mux
      if (k < edo_dram_pkg::DRA_LOW_N) begin : g_lo
         assign pin_col[edo_dram_pkg::SYS_PIN_TOP - k] = x16_next
            ? addr_next[k + edo_dram_pkg::COL16_BASE]
            : addr_next[k + edo_dram_pkg::COL32_BASE];
         assign pin_row[edo_dram_pkg::SYS_PIN_TOP - k] = x16_next
            ? addr_next[k + edo_dram_pkg::ROW16_BASE]
            : addr_next[k + edo_dram_pkg::ROW32_BASE];
      end else begin : g_hi
         localparam int J = (k - edo_dram_pkg::DRA_LOW_N)
            * edo_dram_pkg::HI_STRIDE;
         assign pin_col[edo_dram_pkg::SYS_PIN_TOP - k] = x16_next
            ? addr_next[J + edo_dram_pkg::COL16_HI_BASE]
            : addr_next[J + edo_dram_pkg::COL32_HI_BASE];
         assign pin_row[edo_dram_pkg::SYS_PIN_TOP - k] = x16_next
            ? addr_next[J + edo_dram_pkg::ROW16_HI_BASE]
            : addr_next[J + edo_dram_pkg::ROW32_HI_BASE];
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      timer_next = (timer_reg == 4'h0) ? 4'h0 : 4'(timer_reg - 4'h1);
      addr_next = addr_reg;
      units_next = units_reg;
      x16_next = x16_reg;
      fast_next = fast_reg;
      late_next = late_reg;
      write_next = write_reg;
      size_next = size_reg;
      ctrl_next = column_ctrl;
      use_col_next = use_col_reg;
      oe_next = dq_oe;
      accept = 1'b0;
      open_row = 1'b0;
      start_col = 1'b0;
      err_next = 1'b0;
      ref_start = 1'b0;
      step = x16_reg ? ((size_reg == edo_dram_pkg::SIZE_BYTE)
         ? edo_dram_pkg::STEP_ONE : edo_dram_pkg::STEP_TWO)
         : 32'(edo_dram_pkg::STEP_ONE << size_reg);
      case (state_reg)
         S_IDLE: begin
            if (ref_pend_reg) begin
               ref_start = 1'b1;
               fast_next = bus_fast;
               ctrl_next.cas_n = 4'h0;
               timer_next = 4'(t_cp(bus_fast) - 4'h1);
               state_next = S_REF_CAS;
            end else if (req_valid && req_ready) begin
               accept = 1'b1;
               if (req.addr[edo_dram_pkg::PREFIX_HI:edo_dram_pkg::PREFIX_LO]
                  != edo_dram_pkg::BANK0_PREFIX &&
                  req.addr[edo_dram_pkg::PREFIX_HI:edo_dram_pkg::PREFIX_LO]
                  != edo_dram_pkg::BANK1_PREFIX) begin
                  err_next = 1'b1;
               end else begin
                  addr_next = req.addr;
                  x16_next = sys_config_reg_two[edo_dram_pkg::WIDTH_SEL_BIT]
                     == edo_dram_pkg::WIDTH_X16;
                  fast_next = bus_fast;
                  late_next = bus_fast || dram_is_edo;
                  write_next = req.write;
                  size_next = req.size;
                  units_next = {1'b0, (req.beats == 4'h0) ? 4'h1 : req.beats};
                  if (x16_next && req.size == edo_dram_pkg::SIZE_WORD) begin
                     units_next = 5'(units_next << 1);
                  end
                  open_row = 1'b1;
               end
            end
         end
         S_ROW: begin
            if (timer_reg == 4'h0) begin
               start_col = 1'b1;
            end
         end
         S_CAS_LO: begin
            if (timer_reg == 4'h0) begin
               ctrl_next.cas_n = 4'hF;
               timer_next = 4'(t_cp(fast_reg) - 4'h1);
               state_next = S_CAS_HI;
            end
         end
         S_CAS_HI: begin
            if (timer_reg == 4'h0) begin
               units_next = 5'(units_reg - 5'h1);
               addr_next = 32'(addr_reg + step);
               if (units_reg == 5'h1 || (addr_next & (x16_reg
                  ? edo_dram_pkg::PAGE_MASK_X16
                  : edo_dram_pkg::PAGE_MASK_X32)) == 32'h0) begin
                  ctrl_next = edo_dram_pkg::CTRL_IDLE;
                  oe_next = 1'b0;
                  timer_next = 4'(t_rp(fast_reg) - 4'h1);
                  state_next = S_PRECH;
               end else begin
                  start_col = 1'b1;
               end
            end
         end
         S_PRECH: begin
            if (timer_reg == 4'h0) begin
               if (units_reg != 5'h0) begin
                  open_row = 1'b1;
               end else begin
                  state_next = S_IDLE;
               end
            end
         end
         S_REF_CAS: begin
            if (timer_reg == 4'h0) begin
               ctrl_next.ras_n = 2'h0;
               timer_next = 4'(t_rref(fast_reg) - 4'h1);
               state_next = S_REF_RAS;
            end
         end
         S_REF_RAS: begin
            if (timer_reg == 4'h0) begin
               ctrl_next = edo_dram_pkg::CTRL_IDLE;
               timer_next = 4'(t_rp(fast_reg) - 4'h1);
               state_next = S_PRECH;
            end
         end
         default: begin
            ctrl_next = edo_dram_pkg::CTRL_IDLE;
            state_next = S_IDLE;
         end
      endcase
      if (open_row) begin
         // Bank bit keeps the two banks 256 Mbytes apart
         ctrl_next.ras_n[addr_next[edo_dram_pkg::BANK_BIT]] = 1'b0;
         use_col_next = 1'b0;
         timer_next = 4'(t_rcd(fast_next) - 4'h1);
         state_next = S_ROW;
      end
      if (start_col) begin
         ctrl_next.cas_n = ~lanes_for(size_next, addr_next[1:0],
            x16_next);
         ctrl_next.we_n = ~write_next;
         use_col_next = 1'b1;
         oe_next = write_next;
         timer_next = 4'(t_cas(fast_reg) - 4'h1);
         state_next = S_CAS_LO;
      end
      load_wr = start_col && write_next;
      cap_now = state_reg == S_CAS_HI && !write_reg && (late_reg
         ? timer_reg == 4'h0
         : hi_first_reg);
      ref_pend_next = ((ref_cnt_reg == 16'h0) && (refresh_period_reg
         != 16'h0)) || (ref_pend_reg && !ref_start);
      ready_next = state_next == S_IDLE && !ref_pend_next && !accept;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         timer_reg <= 4'h0;
         addr_reg <= 32'h0;
         units_reg <= 5'h0;
         x16_reg <= 1'b0;
         fast_reg <= 1'b0;
         late_reg <= 1'b0;
         write_reg <= 1'b0;
         size_reg <= 2'h0;
         use_col_reg <= 1'b0;
         hi_first_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         addr_reg <= addr_next;
         units_reg <= units_next;
         x16_reg <= x16_next;
         fast_reg <= fast_next;
         late_reg <= late_next;
         write_reg <= write_next;
         size_reg <= size_next;
         use_col_reg <= use_col_next;
         hi_first_reg <= state_next == S_CAS_HI && state_reg != S_CAS_HI;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         column_ctrl <= edo_dram_pkg::CTRL_IDLE;
         sys_addr_hi <= 13'h0;
         dq_oe <= 1'b0;
         dq_out <= 32'h0;
      end else begin
         column_ctrl <= ctrl_next;
         sys_addr_hi <= use_col_next ? pin_col : pin_row;
         dq_oe <= oe_next;
         if (load_wr) begin
            if (x16_next) begin
               dq_out <= {16'h0, addr_next[1] ? wdata[31:16] : wdata[15:0]};
            end else begin
               dq_out <= wdata;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Refresh interval counter
   // ----------------------------------------------------------------
   // A period of zero stops refresh altogether
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ref_cnt_reg <= 16'h0;
         ref_pend_reg <= 1'b0;
      end else begin
         ref_cnt_reg <= (ref_cnt_reg == 16'h0) ? refresh_period_reg
            : 16'(ref_cnt_reg - 16'h1);
         ref_pend_reg <= ref_pend_next;
      end
   end

   // ----------------------------------------------------------------
   // Read capture and requester handshake
   // ----------------------------------------------------------------
   // Capture strobe is delayed to line up with the two-stage sync
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1_reg <= 32'h0;
         dq_s2_reg <= 32'h0;
         cap_pipe_reg <= 2'h0;
         half_pipe_reg <= 2'h0;
         end_pipe_reg <= 2'h0;
         rdata <= 32'h0;
      end else begin
         dq_s1_reg <= dq_in;
         dq_s2_reg <= dq_s1_reg;
         cap_pipe_reg <= {cap_pipe_reg[0], cap_now};
         half_pipe_reg <= {half_pipe_reg[0], addr_reg[1]};
         end_pipe_reg <= {end_pipe_reg[0],
            ends_beat(size_reg, addr_reg[1], x16_reg)};
         if (cap_pipe_reg[1]) begin
            if (!x16_reg) begin
               rdata <= dq_s2_reg;
            end else if (half_pipe_reg[1]) begin
               rdata[31:16] <= dq_s2_reg[15:0];
            end else begin
               rdata[15:0] <= dq_s2_reg[15:0];
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         req_ready <= 1'b0;
         req_error <= 1'b0;
         beat_done <= 1'b0;
      end else begin
         req_ready <= ready_next;
         req_error <= err_next;
         beat_done <= (load_wr && ends_beat(size_next, addr_next[1],
            x16_next)) || (cap_pipe_reg[1] && end_pipe_reg[1]);
      end
   end

endmodule // edo_dram_controller

// File: edo_dram_checker_assertions.sv
// Port-level properties of the DRAM controller
`timescale 1ns/1ps
module edo_dram_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [31:0] sys_config_reg_two,
   input wire logic bus_fast,
   input wire logic dram_is_edo,
   input wire logic req_valid,
   input wire edo_dram_pkg::bus_req_t req,
   input wire logic req_ready,
   input wire logic req_error,
   input wire logic beat_done,
   input wire edo_dram_pkg::dram_ctrl_t column_ctrl,
   input wire logic [27:15] sys_addr_hi
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic acc, good, fall, x16_reg, pend_reg;
   logic [1:0] sz_reg;
   logic [31:0] a_reg;
   logic [27:15] row, col;
   logic [3:0] lanes;
   assign acc = req_valid && req_ready;
   assign good = req.addr[31:29] == 3'h6;
   assign fall = pend_reg && column_ctrl.cas_n != 4'hF;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         a_reg <= '0;
         sz_reg <= 2'h0;
         x16_reg <= 1'h0;
         pend_reg <= 1'h0;
      end else if (acc) begin
         a_reg <= req.addr;
         sz_reg <= req.size;
         x16_reg <= sys_config_reg_two[2];
         pend_reg <= good;
      end else if (fall) begin
         pend_reg <= 1'h0;
      end
   end
   // x16 shifts every source bit down by one
   always_comb begin
      for (int k = 0; k < 13; k++) begin
         row[27-k] = a_reg[k < 8 ? 10+k-x16_reg : 18+2*(k-8)-x16_reg];
         col[27-k] = a_reg[k < 8 ? 2+k-x16_reg : 19+2*(k-8)-x16_reg];
      end
      lanes = ~(4'h1 << a_reg[1:0]);
      if (sz_reg == 2'h1) lanes = a_reg[1] ? 4'h3 : 4'hC;
      if (sz_reg == 2'h2) lanes = 4'h0;
   end
   a_ready_drops: assert property (acc && good |=> !req_ready [*4])
      else $error("ready stayed high after accept");
   a_error_ready: assert property (acc && !good |=> !req_ready)
      else $error("ready stayed high after bad prefix");
   a_prefix_error: assert property (acc |=> req_error == !$past(good))
      else $error("error pulse does not match prefix");
   a_bank_zero: assert property (acc && req.addr[31:28] == 4'hC |=>
      column_ctrl.ras_n == 2'h2)
      else $error("bank 0 row strobe wrong");
   a_bank_one: assert property (acc && req.addr[31:28] == 4'hD |=>
      column_ctrl.ras_n == 2'h1)
      else $error("bank 1 row strobe wrong");
   a_row_before_col: assert property (acc && good |=>
      column_ctrl.cas_n == 4'hF [*4])
      else $error("column strobe before row delay");
   a_row_addr: assert property (acc && good |=> sys_addr_hi == row)
      else $error("row address mapping wrong");
   a_col_addr: assert property (fall |-> sys_addr_hi[26:15] == col[26:15]
      && (x16_reg || sys_addr_hi[27] == col[27]))
      else $error("column address mapping wrong");
   a_lane_mask: assert property (fall && !x16_reg |->
      column_ctrl.cas_n == lanes)
      else $error("column strobes do not match lanes");
   a_write_boot: assert property (acc && good && req.write && !bus_fast
      && !sys_config_reg_two[2] |-> ##9 beat_done)
      else $error("boot write beat late");
   a_read_fpm: assert property (acc && good && !req.write && !bus_fast
      && !dram_is_edo && !sys_config_reg_two[2] |-> ##18 beat_done)
      else $error("fast page read beat late");
   a_read_edo: assert property (acc && good && !req.write && !bus_fast
      && dram_is_edo && !sys_config_reg_two[2] |-> ##22 beat_done)
      else $error("EDO read beat late");
   c_write: cover property (acc && req.write);
   c_error: cover property (req_error);
   c_refresh: cover property (column_ctrl.ras_n == 2'h0);
endmodule // edo_dram_checker

bind edo_dram_controller edo_dram_checker chk (.clock(clock), .rst_n(rst_n),
   .sys_config_reg_two(sys_config_reg_two), .bus_fast(bus_fast),
   .dram_is_edo(dram_is_edo), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .req_error(req_error), .beat_done(beat_done),
   .column_ctrl(column_ctrl), .sys_addr_hi(sys_addr_hi));

// File: edo_dram_model.sv
// Behavioural EDO / fast page DRAM seen from the controller pins
`timescale 1ns/1ps
module edo_dram_model (
   input wire logic clock,
   input wire edo_dram_pkg::dram_ctrl_t column_ctrl,
   input wire logic [27:15] sys_addr_hi,
   input wire logic [31:0] dq_out,
   input wire logic dq_oe,
   input wire logic edo_mode,
   output logic [31:0] dq_in
);
   logic [31:0] mem [0:511];
   logic [31:0] last_reg = '0;
   logic hold_reg = 1'h0;
   logic [8:0] a;
   always_comb begin
      a[8] = column_ctrl.ras_n[0];
      for (int k = 0; k < 8; k++) a[k] = sys_addr_hi[27-k];
   end
   always @(posedge clock) begin
      if (column_ctrl.cas_n != 4'hF && column_ctrl.ras_n != 2'h3) begin
         for (int i = 0; i < 4; i++)
            if (!column_ctrl.cas_n[i] && !column_ctrl.we_n && dq_oe)
               mem[a][8*i+:8] <= dq_out[8*i+:8];
         last_reg <= mem[a];
         hold_reg <= 1'h1;
      end else if (column_ctrl.ras_n == 2'h3 || !edo_mode) begin
         hold_reg <= 1'h0;
      end
   end
   // EDO holds data through strobe high; a released bus shows junk
   assign dq_in = dq_oe ? dq_out : (hold_reg ? last_reg : ~last_reg);
endmodule // edo_dram_model

// File: edo_dram_controller_tb_top.sv
// Self-checking bench for the DRAM controller
`timescale 1ns/1ps
module edo_dram_controller_tb_top;
   typedef struct {
      logic [31:0] addr;
      logic [1:0] size;
      logic x16, fast, edo;
      logic [31:0] data, mask;
   } row_t;
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic [31:0] cfg = '0;
   logic bus_fast = 1'h0;
   logic dram_is_edo = 1'h0;
   logic [15:0] refresh = '0;
   logic req_valid = 1'h0;
   edo_dram_pkg::bus_req_t req = '0;
   logic [31:0] wdata = '0;
   logic req_ready, req_error, beat_done, dq_oe, err;
   logic [31:0] rdata, dq_in, dq_out;
   logic [31:0] got [0:15];
   edo_dram_pkg::dram_ctrl_t ctrl;
   logic [27:15] addr_hi;
   logic [1:0] ras_prev = 2'h3;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   int ras_ups = 0;
   int refreshes = 0;
   row_t rows [0:5] = '{
      '{32'hC0000104, 2'h2, 1'h0, 1'h0, 1'h0, 32'h12345678, 32'hFFFFFFFF},
      '{32'hD0000203, 2'h0, 1'h0, 1'h0, 1'h1, 32'hAB000000, 32'hFF000000},
      '{32'hC0000002, 2'h1, 1'h0, 1'h1, 1'h1, 32'hBEEF0000, 32'hFFFF0000},
      '{32'hD0000010, 2'h2, 1'h1, 1'h0, 1'h0, 32'hCAFEF00D, 32'hFFFFFFFF},
      '{32'hC0000021, 2'h0, 1'h1, 1'h1, 1'h1, 32'h0000A500, 32'h0000FF00},
      '{32'hDFFFFFFC, 2'h2, 1'h0, 1'h1, 1'h1, 32'h5A5AC3C3, 32'hFFFFFFFF}};

   always #2.5 clock = ~clock;

   edo_dram_controller uut (.clock(clock), .rst_n(rst_n),
      .sys_config_reg_two(cfg), .bus_fast(bus_fast),
      .dram_is_edo(dram_is_edo), .refresh_period_reg(refresh),
      .req_valid(req_valid), .req(req), .wdata(wdata),
      .req_ready(req_ready), .req_error(req_error), .beat_done(beat_done),
      .rdata(rdata), .column_ctrl(ctrl), .sys_addr_hi(addr_hi),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
   edo_dram_model dram (.clock(clock), .column_ctrl(ctrl),
      .sys_addr_hi(addr_hi), .dq_out(dq_out), .dq_oe(dq_oe),
      .edo_mode(dram_is_edo | bus_fast), .dq_in(dq_in));

   always @(posedge clock) begin
      cycles++;
      ras_ups += (ctrl.ras_n == 2'h3 && ras_prev != 2'h3);
      refreshes += (ctrl.ras_n == 2'h0 && ras_prev != 2'h0);
      ras_prev = ctrl.ras_n;
      if (cycles == 20000) begin
         bad_count++;
         $display("ERROR %0t timeout", $time);
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string what);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t %s got %h want %h", $time, what, g, e);
      end
   endtask

   // Inputs move on the falling edge; ends once the access has closed
   task automatic xfer(input logic [31:0] a, input logic w,
      input logic [1:0] sz, input logic [3:0] nb, input logic [31:0] d);
      err = 1'h0;
      req = '{addr: a, write: w, size: sz, beats: nb};
      wdata = d;
      req_valid = 1'h1;
      while (req_ready !== 1'h1) @(negedge clock);
      @(negedge clock);
      req_valid = 1'h0;
      for (int i = 0; i < nb && !err; i++) begin
         while (beat_done !== 1'h1 && req_error !== 1'h1) @(negedge clock);
         err = req_error;
         got[i] = rdata;
         wdata = d + i + 1;
         @(negedge clock);
      end
      while (req_ready !== 1'h1) @(negedge clock);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      int n;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk(32'({ctrl, dq_oe, req_ready}), 32'({edo_dram_pkg::CTRL_IDLE,
         2'h0}), "reset");
      rst_n = 1'h1;
      $display("test reset done");
      foreach (rows[r]) begin
         cfg = {29'h0, rows[r].x16, 2'h0};
         bus_fast = rows[r].fast;
         dram_is_edo = rows[r].edo;
         xfer(rows[r].addr, 1'h1, rows[r].size, 4'h1, rows[r].data);
         xfer(rows[r].addr, 1'h0, rows[r].size, 4'h1, '0);
         chk(got[0] & rows[r].mask, rows[r].data & rows[r].mask, "row");
         $display("test row %0d done", r);
      end
      cfg = '0;
      bus_fast = 1'h0;
      dram_is_edo = 1'h1;
      xfer(32'hC00003F8, 1'h1, 2'h2, 4'h4, 32'h11110000);
      n = ras_ups;
      xfer(32'hC00003F8, 1'h0, 2'h2, 4'h4, '0);
      for (int i = 0; i < 4; i++)
         chk(got[i], 32'h11110000 + i, "burst data");
      chk(32'(ras_ups - n), 32'h2, "row reopen");
      $display("test burst done");
      n = ras_ups;
      xfer(32'h40000000, 1'h0, 2'h2, 4'h1, '0);
      chk(32'(err), 32'h1, "bad prefix");
      chk(32'(ras_ups - n), 32'h0, "no cycle");
      $display("test prefix done");
      refresh = 16'h0100;
      n = refreshes;
      repeat (600) @(negedge clock);
      chk(32'(refreshes - n >= 2), 32'h1, "refresh count");
      xfer(32'hC0000104, 1'h0, 2'h2, 4'h1, '0);
      chk(got[0], 32'h12345678, "after refresh");
      $display("test refresh done");
      wrap_up();
   end
endmodule // edo_dram_controller_tb_top
